// >>> common/irq_mask_consts.svh
// Register offsets, field positions and reset values of the interrupt mask block
// Functional notes
// - Mask bit 0 passes its event to the interrupt; 1 blocks it.
// - Boost mask register bit 5 gates the boost low battery interrupt.
// - Boost mask register bit 3 gates the boost 32 s timeout interrupt.
// - Charger mask has a bit suppressing the thermal regulation loop interrupt.
// - Charger mask has a bit suppressing the input voltage regulation loop interrupt.
// - Charger mask has a bit suppressing the battery overvoltage interrupt.
// - Input voltage regulation event is a warning raised while that loop is active.
`ifndef IRQ_MASK_CONSTS_SVH
`define IRQ_MASK_CONSTS_SVH
`define CHARGER_MASK_ADDR    8'h0c
`define BOOST_MASK_ADDR      8'h0d
`define MASK_RESET           8'h00
`define BOOST_INPUT_OV_BIT   7
`define BOOST_OVERLOAD_BIT   6
`define BOOST_LOW_BATT_BIT   5
`define BOOST_TIMEOUT_BIT    3
`define BOOST_MASK_USED      8'he8
`define REVERSE_PROT_BIT     7
`define BATTERY_OV_BIT       5
`define CHARGE_DONE_BIT      4
`define RECHARGE_BIT         3
`define CHARGE_TIMEOUT_BIT   2
`define THERMAL_LOOP_BIT     1
`define INPUT_VREG_LOOP_BIT  0
`define CHARGER_MASK_USED    8'hbf
`endif

// >>> common/irq_mask_pkg.sv
// Types shared by the interrupt mask block
package irq_mask_pkg;
   typedef logic [7:0] reg8_t;
endpackage

// >>> logic/mask_gate.sv
// Per-bit event gating for one 8-bit mask register
`timescale 1ns/10ps
module mask_gate
   import irq_mask_pkg::*;
(
   // Event flags and masks
   input  wire reg8_t flags,
   input  wire reg8_t mask,
   input  wire reg8_t used,
   // Result
   output logic       any_pending
);
   reg8_t pass;
   genvar i;
   generate
      for (i = 0; i < 8; i++) begin : g_bit
         assign pass[i] = flags[i] & ~mask[i] & used[i];
      end
   endgenerate
   assign any_pending = |pass;
endmodule

// >>> logic/charger_boost_irq_masking.sv
// Mask registers and open-drain interrupt output of the charger
`timescale 1ns/10ps
`include "irq_mask_consts.svh"
module charger_boost_irq_masking
   import irq_mask_pkg::*;
(
   // Clock and reset
   input  wire  logic sys_clk,
   input  wire  logic arst_n,
   // Register port
   input  wire  logic       reg_wr,
   input  wire  logic [7:0] reg_addr,
   input  wire  reg8_t      reg_wdata,
   output reg8_t            reg_rdata,
   // Event flags from the charger and boost logic
   input  wire  reg8_t      charger_flags,
   input  wire  reg8_t      boost_flags,
   // Open-drain interrupt, active low on the wire
   output logic             irq_o,
   output logic             irq_oe
);
   reg8_t charger_irq_mask_q;
   reg8_t boost_irq_mask_q;
   logic  chg_pend;
   logic  bst_pend;
   logic  irq_q;

   // Named mask fields, read by the checks below
   logic  reverse_prot_mask;
   logic  battery_ov_mask;
   logic  charge_done_mask;
   logic  recharge_mask;
   logic  charge_timeout_mask;
   logic  thermal_loop_mask;
   logic  input_vreg_loop_mask;
   logic  boost_input_ov_mask;
   logic  boost_overload_mask;
   logic  boost_low_batt_mask;
   logic  boost_timeout_mask;

   // Masks reset to zero so every used event reaches the pin by default
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         charger_irq_mask_q <= `MASK_RESET;
      end else if (reg_wr && reg_addr == `CHARGER_MASK_ADDR) begin
         charger_irq_mask_q <= reg_wdata;
      end
   end

   // Reserved bits of the boost mask are plain storage, read back as written
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         boost_irq_mask_q <= `MASK_RESET;
      end else if (reg_wr && reg_addr == `BOOST_MASK_ADDR) begin
         boost_irq_mask_q <= reg_wdata;
      end
   end

   // Taps only; the gating itself stays per bit in the gate module
   assign reverse_prot_mask    = charger_irq_mask_q[`REVERSE_PROT_BIT];
   assign battery_ov_mask      = charger_irq_mask_q[`BATTERY_OV_BIT];
   assign charge_done_mask     = charger_irq_mask_q[`CHARGE_DONE_BIT];
   assign recharge_mask        = charger_irq_mask_q[`RECHARGE_BIT];
   assign charge_timeout_mask  = charger_irq_mask_q[`CHARGE_TIMEOUT_BIT];
   assign thermal_loop_mask    = charger_irq_mask_q[`THERMAL_LOOP_BIT];
   assign input_vreg_loop_mask = charger_irq_mask_q[`INPUT_VREG_LOOP_BIT];
   assign boost_input_ov_mask  = boost_irq_mask_q[`BOOST_INPUT_OV_BIT];
   assign boost_overload_mask  = boost_irq_mask_q[`BOOST_OVERLOAD_BIT];
   assign boost_low_batt_mask  = boost_irq_mask_q[`BOOST_LOW_BATT_BIT];
   assign boost_timeout_mask   = boost_irq_mask_q[`BOOST_TIMEOUT_BIT];

   always_comb begin
      unique case (reg_addr)
         `CHARGER_MASK_ADDR: reg_rdata = charger_irq_mask_q;
         `BOOST_MASK_ADDR:   reg_rdata = boost_irq_mask_q;
         default:            reg_rdata = 8'h00;
      endcase
   end

   // Input regulation warning enters as a level while its loop is active
   mask_gate u_chg (
      .flags       (charger_flags),
      .mask        (charger_irq_mask_q),
      .used        (`CHARGER_MASK_USED),
      .any_pending (chg_pend)
   );

   mask_gate u_bst (
      .flags       (boost_flags),
      .mask        (boost_irq_mask_q),
      .used        (`BOOST_MASK_USED),
      .any_pending (bst_pend)
   );

   // Registered so the pin never glitches on flag skew
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= chg_pend | bst_pend;
      end
   end

   assign irq_o  = 1'b0;
   assign irq_oe = irq_q;

   a_low_batt_gate: assert property (@(posedge sys_clk) disable iff (!arst_n)
      (boost_flags == 8'h20 && charger_flags == 8'h00 && boost_irq_mask_q[5])
      |=> !irq_oe)
      else $error("masked low battery event drove the interrupt");
   a_timeout_pass: assert property (@(posedge sys_clk) disable iff (!arst_n)
      (boost_flags[3] && !boost_irq_mask_q[3]) |=> irq_oe)
      else $error("unmasked boost timeout did not raise the interrupt");
   a_thermal_pass: assert property (@(posedge sys_clk) disable iff (!arst_n)
      (charger_flags[1] && !charger_irq_mask_q[1]) |=> irq_oe)
      else $error("unmasked thermal event did not raise the interrupt");
   a_vreg_pass: assert property (@(posedge sys_clk) disable iff (!arst_n)
      (charger_flags[0] && !charger_irq_mask_q[0]) |=> irq_oe)
      else $error("unmasked input regulation event did not raise the interrupt");
   a_batt_ov_gate: assert property (@(posedge sys_clk) disable iff (!arst_n)
      (charger_flags == 8'h20 && boost_flags == 8'h00 && charger_irq_mask_q[5])
      |=> !irq_oe)
      else $error("masked battery overvoltage drove the interrupt");
   a_irq_release: assert property (@(posedge sys_clk) disable iff (!arst_n)
      (((charger_flags & ~charger_irq_mask_q & 8'hbf) == 8'h00)
       && ((boost_flags & ~boost_irq_mask_q & 8'he8) == 8'h00)) |=> !irq_oe)
      else $error("interrupt held with no unmasked flag");
   a_mask_write: assert property (@(posedge sys_clk) disable iff (!arst_n)
      (reg_wr && reg_addr == 8'h0d) |=> boost_irq_mask_q == $past(reg_wdata))
      else $error("boost mask write not stored");
   a_pin_low_only: assert property (@(posedge sys_clk) disable iff (!arst_n)
      irq_oe |-> !irq_o)
      else $error("interrupt pin driven high");

   // Each used event reaches the pin while its mask bit is clear
   a_rev_prot_pass: assert property (@(posedge sys_clk) disable iff (!arst_n)
      (charger_flags[`REVERSE_PROT_BIT] && !reverse_prot_mask) |=> irq_oe)
      else $error("unmasked reverse protection event did not raise the interrupt");
   a_batt_ov_pass: assert property (@(posedge sys_clk) disable iff (!arst_n)
      (charger_flags[`BATTERY_OV_BIT] && !battery_ov_mask) |=> irq_oe)
      else $error("unmasked battery overvoltage did not raise the interrupt");
   a_charge_done_pass: assert property (@(posedge sys_clk) disable iff (!arst_n)
      (charger_flags[`CHARGE_DONE_BIT] && !charge_done_mask) |=> irq_oe)
      else $error("unmasked charge done event did not raise the interrupt");
   a_recharge_pass: assert property (@(posedge sys_clk) disable iff (!arst_n)
      (charger_flags[`RECHARGE_BIT] && !recharge_mask) |=> irq_oe)
      else $error("unmasked recharge event did not raise the interrupt");
   a_chg_timeout_pass: assert property (@(posedge sys_clk) disable iff (!arst_n)
      (charger_flags[`CHARGE_TIMEOUT_BIT] && !charge_timeout_mask) |=> irq_oe)
      else $error("unmasked charge timeout did not raise the interrupt");
   a_input_ov_pass: assert property (@(posedge sys_clk) disable iff (!arst_n)
      (boost_flags[`BOOST_INPUT_OV_BIT] && !boost_input_ov_mask) |=> irq_oe)
      else $error("unmasked boost input overvoltage did not raise the interrupt");
   a_overload_pass: assert property (@(posedge sys_clk) disable iff (!arst_n)
      (boost_flags[`BOOST_OVERLOAD_BIT] && !boost_overload_mask) |=> irq_oe)
      else $error("unmasked boost overload did not raise the interrupt");
   a_low_batt_pass: assert property (@(posedge sys_clk) disable iff (!arst_n)
      (boost_flags[`BOOST_LOW_BATT_BIT] && !boost_low_batt_mask) |=> irq_oe)
      else $error("unmasked low battery event did not raise the interrupt");

   // A lone masked event leaves the pin released
   a_rev_prot_gate: assert property (@(posedge sys_clk) disable iff (!arst_n)
      ($onehot(charger_flags) && charger_flags[`REVERSE_PROT_BIT] && boost_flags == 8'h00
       && reverse_prot_mask) |=> !irq_oe)
      else $error("masked reverse protection event drove the interrupt");
   a_charge_done_gate: assert property (@(posedge sys_clk) disable iff (!arst_n)
      ($onehot(charger_flags) && charger_flags[`CHARGE_DONE_BIT] && boost_flags == 8'h00
       && charge_done_mask) |=> !irq_oe)
      else $error("masked charge done event drove the interrupt");
   a_recharge_gate: assert property (@(posedge sys_clk) disable iff (!arst_n)
      ($onehot(charger_flags) && charger_flags[`RECHARGE_BIT] && boost_flags == 8'h00
       && recharge_mask) |=> !irq_oe)
      else $error("masked recharge event drove the interrupt");
   a_chg_timeout_gate: assert property (@(posedge sys_clk) disable iff (!arst_n)
      ($onehot(charger_flags) && charger_flags[`CHARGE_TIMEOUT_BIT] && boost_flags == 8'h00
       && charge_timeout_mask) |=> !irq_oe)
      else $error("masked charge timeout drove the interrupt");
   a_thermal_gate: assert property (@(posedge sys_clk) disable iff (!arst_n)
      ($onehot(charger_flags) && charger_flags[`THERMAL_LOOP_BIT] && boost_flags == 8'h00
       && thermal_loop_mask) |=> !irq_oe)
      else $error("masked thermal event drove the interrupt");
   a_vreg_gate: assert property (@(posedge sys_clk) disable iff (!arst_n)
      ($onehot(charger_flags) && charger_flags[`INPUT_VREG_LOOP_BIT] && boost_flags == 8'h00
       && input_vreg_loop_mask) |=> !irq_oe)
      else $error("masked input regulation event drove the interrupt");
   a_input_ov_gate: assert property (@(posedge sys_clk) disable iff (!arst_n)
      ($onehot(boost_flags) && boost_flags[`BOOST_INPUT_OV_BIT] && charger_flags == 8'h00
       && boost_input_ov_mask) |=> !irq_oe)
      else $error("masked boost input overvoltage drove the interrupt");
   a_overload_gate: assert property (@(posedge sys_clk) disable iff (!arst_n)
      ($onehot(boost_flags) && boost_flags[`BOOST_OVERLOAD_BIT] && charger_flags == 8'h00
       && boost_overload_mask) |=> !irq_oe)
      else $error("masked boost overload drove the interrupt");
   a_timeout_gate: assert property (@(posedge sys_clk) disable iff (!arst_n)
      ($onehot(boost_flags) && boost_flags[`BOOST_TIMEOUT_BIT] && charger_flags == 8'h00
       && boost_timeout_mask) |=> !irq_oe)
      else $error("masked boost timeout drove the interrupt");

   // Reserved positions never reach the pin, whatever their mask bits hold
   a_reserved_quiet: assert property (@(posedge sys_clk) disable iff (!arst_n)
      ((charger_flags & `CHARGER_MASK_USED) == 8'h00
       && (boost_flags & `BOOST_MASK_USED) == 8'h00) |=> !irq_oe)
      else $error("reserved event position drove the interrupt");

   // Writes land one edge later; other addresses leave both masks alone
   a_charger_write: assert property (@(posedge sys_clk) disable iff (!arst_n)
      (reg_wr && reg_addr == `CHARGER_MASK_ADDR) |=> charger_irq_mask_q == $past(reg_wdata))
      else $error("charger mask write not stored");
   a_charger_hold: assert property (@(posedge sys_clk) disable iff (!arst_n)
      !(reg_wr && reg_addr == `CHARGER_MASK_ADDR) |=> $stable(charger_irq_mask_q))
      else $error("charger mask changed without a write");
   a_boost_hold: assert property (@(posedge sys_clk) disable iff (!arst_n)
      !(reg_wr && reg_addr == `BOOST_MASK_ADDR) |=> $stable(boost_irq_mask_q))
      else $error("boost mask changed without a write");
   a_unmapped_read: assert property (@(posedge sys_clk) disable iff (!arst_n)
      (reg_addr != `CHARGER_MASK_ADDR && reg_addr != `BOOST_MASK_ADDR) |-> reg_rdata == 8'h00)
      else $error("unmapped address returned data");

   c_irq_rise: cover property (@(posedge sys_clk) disable iff (!arst_n) $rose(irq_oe));
   c_irq_fall: cover property (@(posedge sys_clk) disable iff (!arst_n) $fell(irq_oe));
   c_masked: cover property (@(posedge sys_clk) disable iff (!arst_n)
      (charger_flags != 8'h00) && !irq_oe);
   c_boost_masked: cover property (@(posedge sys_clk) disable iff (!arst_n)
      (boost_flags != 8'h00) && !irq_oe);
   c_both_pend: cover property (@(posedge sys_clk) disable iff (!arst_n) chg_pend && bst_pend);
endmodule

// >>> testbench/charger_boost_irq_masking_tb.sv
// Self-checking bench for the interrupt mask block
`timescale 1ns/10ps
`include "irq_mask_consts.svh"
module charger_boost_irq_masking_tb;
   import irq_mask_pkg::*;
   logic       sys_clk       = 1'b0;
   logic       arst_n        = 1'b0;
   logic       reg_wr        = 1'b0;
   logic [7:0] reg_addr      = 8'h00;
   reg8_t      reg_wdata     = 8'h00;
   reg8_t      reg_rdata;
   reg8_t      charger_flags = 8'h00;
   reg8_t      boost_flags   = 8'h00;
   logic       irq_o;
   logic       irq_oe;
   int         fails         = 0;
   int         num_checks    = 0;
   always #50 sys_clk = ~sys_clk;
   charger_boost_irq_masking i_charger_boost_irq_masking (.sys_clk(sys_clk), .arst_n(arst_n),
      .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .charger_flags(charger_flags), .boost_flags(boost_flags), .irq_o(irq_o), .irq_oe(irq_oe));
   task automatic cmp(input string name, input reg8_t exp, input reg8_t got);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic cmp_irq(input logic exp);
      num_checks++;
      if (irq_oe !== exp) begin
         fails++;
         $display("[ERR] irq_oe expected %b seen %b", exp, irq_oe);
      end
   endtask
   task automatic wr(input logic [7:0] a, input reg8_t d);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input reg8_t exp);
      @(posedge sys_clk);
      reg_addr <= a;
      @(negedge sys_clk);
      cmp("reg_rdata", exp, reg_rdata);
   endtask
   // Masks first, then flags; pin is registered so check two edges later
   task automatic ev(input reg8_t c, input reg8_t b, input reg8_t mc, input reg8_t mb,
                     input logic exp);
      wr(`CHARGER_MASK_ADDR, mc);
      wr(`BOOST_MASK_ADDR, mb);
      @(posedge sys_clk);
      charger_flags <= c;
      boost_flags <= b;
      @(posedge sys_clk);
      @(negedge sys_clk);
      cmp_irq(exp);
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      #1_000_000;
      fails++;
      summarize();
   end
   initial begin
      repeat (5) @(posedge sys_clk);
      arst_n <= 1'b1;
      rd(`BOOST_MASK_ADDR, `MASK_RESET);
      rd(`CHARGER_MASK_ADDR, `MASK_RESET);
      cmp_irq(1'b0);
      wr(`BOOST_MASK_ADDR, 8'h55);
      wr(8'h0e, 8'hff);
      rd(`BOOST_MASK_ADDR, 8'h55);
      rd(8'h0e, 8'h00);
      rd(`CHARGER_MASK_ADDR, `MASK_RESET);
      $display("test registers done");
      // Every bit position, unmasked then masked; unused positions never raise it
      for (int i = 0; i < 8; i++) begin
         ev(8'h01 << i, 8'h00, 8'h00, 8'h00, 1'((`CHARGER_MASK_USED >> i) & 1));
         ev(8'h01 << i, 8'h00, 8'h01 << i, 8'h00, 1'b0);
         ev(8'h00, 8'h01 << i, 8'h00, 8'h00, 1'((`BOOST_MASK_USED >> i) & 1));
         ev(8'h00, 8'h01 << i, 8'h00, 8'h01 << i, 1'b0);
      end
      $display("test bit sweep done");
      ev(8'h00, 8'h20, 8'hff, 8'hdf, 1'b1);
      ev(8'h00, 8'h20, 8'h00, 8'h20, 1'b0);
      ev(8'h00, 8'h08, 8'hff, 8'hf7, 1'b1);
      ev(8'h00, 8'h08, 8'h00, 8'h08, 1'b0);
      ev(8'h02, 8'h00, 8'hfd, 8'hff, 1'b1);
      ev(8'h02, 8'h00, 8'h02, 8'h00, 1'b0);
      ev(8'h01, 8'h00, 8'hfe, 8'hff, 1'b1);
      ev(8'h01, 8'h00, 8'h01, 8'h00, 1'b0);
      ev(8'h20, 8'h00, 8'hdf, 8'hff, 1'b1);
      ev(8'h20, 8'h00, 8'h20, 8'h00, 1'b0);
      ev(8'h21, 8'h08, 8'h01, 8'h00, 1'b1);
      ev(8'h01, 8'h00, 8'h01, 8'h00, 1'b0);
      cmp("irq_o", 8'h00, {7'h00, irq_o});
      $display("test event gating done");
      // Reset in mid-run with an event pending and both masks written
      ev(8'h02, 8'h00, 8'h01, 8'h08, 1'b1);
      rd(`CHARGER_MASK_ADDR, 8'h01);
      rd(`BOOST_MASK_ADDR, 8'h08);
      @(posedge sys_clk);
      arst_n <= 1'b0;
      @(negedge sys_clk);
      cmp_irq(1'b0);
      rd(`CHARGER_MASK_ADDR, `MASK_RESET);
      rd(`BOOST_MASK_ADDR, `MASK_RESET);
      @(posedge sys_clk);
      charger_flags <= 8'h00;
      @(posedge sys_clk);
      arst_n <= 1'b1;
      ev(8'h00, 8'h20, 8'h00, 8'h00, 1'b1);
      $display("test mid-run reset done");
      summarize();
   end
endmodule
